// ===== rtl/temp_monitor_pkg.sv
// Constants for the two-channel temperature monitor core.
// Assumes one 100 MHz clock; analogue converter sits outside.
package temp_monitor_pkg;

  localparam int unsigned CLOCK_HZ       = 100_000_000;
  localparam logic [7:0]  VALUE_RESET    = 8'h80;
  localparam logic [7:0]  LIMIT_HI_RESET = 8'h7F;
  localparam logic [7:0]  LIMIT_LO_RESET = 8'hC9;

  // Status register field positions
  localparam int unsigned ST_BUSY        = 7;
  localparam int unsigned ST_LOCAL_HIGH  = 6;
  localparam int unsigned ST_LOCAL_LOW   = 5;
  localparam int unsigned ST_REMOTE_HIGH = 4;
  localparam int unsigned ST_REMOTE_LOW  = 3;
  localparam int unsigned ST_OPEN        = 2;

  // Conversion rate codes select a start interval in milliseconds
  localparam logic [2:0]  RATE_RESET     = 3'h2;
  localparam int unsigned RATE_CODES     = 8;
  localparam int unsigned BASE_PERIOD_MS = 16;
  localparam int unsigned MS_CYCLES      = CLOCK_HZ / 1000;

  typedef enum logic [3:0]
  {
    SEQ_IDLE   = 4'b0001,
    SEQ_LOCAL  = 4'b0010,
    SEQ_REMOTE = 4'b0100,
    SEQ_WAIT   = 4'b1000
  } seq_state_t;

endpackage

// ===== rtl/limit_compare.sv
// Signed comparison of one channel value against its two limits.
// Assumes all inputs on the same clock; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module limit_compare
(
  // Operands
  input  wire logic [7:0] value_in,
  input  wire logic [7:0] high_limit_in,
  input  wire logic [7:0] low_limit_in,
  // Results
  output logic            above_out,
  output logic            below_out
);

  assign above_out = $signed(value_in) > $signed(high_limit_in);
  assign below_out = $signed(value_in) < $signed(low_limit_in);

endmodule
`default_nettype wire

// ===== rtl/dual_temp_monitor_core.sv
// Sequencer, value store, limit compare and alarm of the monitor.
// Assumes a converter that answers start with done plus result,
// and a serial-bus front end delivering register writes and
// status-read strobes on this clock.
`timescale 1ns/1ps
`default_nettype none
module dual_temp_monitor_core
#(
  parameter int unsigned BASE_PERIOD_MS = temp_monitor_pkg::BASE_PERIOD_MS
)
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       srst_in,
  input  wire logic       clk_en_in,
  // Standby pin, low selects standby
  input  wire logic       standby_select_pin_in,
  // Converter handshake
  output logic            conv_start_out,
  output logic            conv_remote_sel_out,
  input  wire logic       conv_done_in,
  input  wire logic [7:0] conv_result_in,
  input  wire logic       sensor_open_in,
  // Host register writes
  input  wire logic       wr_local_high_in,
  input  wire logic       wr_local_low_in,
  input  wire logic       wr_remote_high_in,
  input  wire logic       wr_remote_low_in,
  input  wire logic       wr_config_in,
  input  wire logic       wr_rate_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       status_read_in,
  // Register contents for host reads
  output logic [7:0]      local_value_out,
  output logic [7:0]      remote_value_out,
  output logic [7:0]      local_high_out,
  output logic [7:0]      local_low_out,
  output logic [7:0]      remote_high_out,
  output logic [7:0]      remote_low_out,
  output logic [7:0]      config_out,
  output logic [2:0]      rate_out,
  output logic [7:0]      status_out,
  // Alarm, active low
  output logic            alarm_n_out
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchroniser and registers

  logic       standby_select_pin_meta_r;
  logic       standby_select_pin_sync_r;
  logic [7:0] local_value_r;
  logic [7:0] remote_value_r;
  logic [7:0] local_high_r;
  logic [7:0] local_low_r;
  logic [7:0] remote_high_r;
  logic [7:0] remote_low_r;
  logic [7:0] config_r;
  logic [2:0] rate_r;
  logic [4:0] flags_r;
  logic [4:0] flags_nxt;
  logic       alarm_latch_r;
  logic       compare_armed_r;
  logic       first_cycle_r;
  logic       start_sampled_r;
  logic       open_r;

  temp_monitor_pkg::seq_state_t state_r;
  temp_monitor_pkg::seq_state_t state_nxt;

  // No reset: the pin level must be valid on the first free edge,
  // else a normal start would be mistaken for a standby start
  always_ff @(posedge clock_in)
  begin
    if (clk_en_in)
    begin
      standby_select_pin_meta_r <= standby_select_pin_in;
      standby_select_pin_sync_r <= standby_select_pin_meta_r;
    end
  end

  // Config bit 6 is the software standby; bit 7 the alarm mask
  wire run_mode    = standby_select_pin_sync_r && !config_r[6];
  wire alarm_mask  = config_r[7];

  ////////////////////////////////////////////////////////////////////
  // Rate interval: BASE_PERIOD_MS << code, in cycles

  localparam int unsigned MS_CYCLES = temp_monitor_pkg::MS_CYCLES;
  localparam int unsigned MAX_MS    = BASE_PERIOD_MS << (temp_monitor_pkg::RATE_CODES - 1);
  localparam int unsigned CNT_W     = $clog2(MAX_MS * MS_CYCLES + 1);

  logic [CNT_W-1:0] wait_cnt_r;
  wire  [CNT_W-1:0] interval_cycles = CNT_W'((BASE_PERIOD_MS * MS_CYCLES) << rate_r);
  wire              wait_done       = (wait_cnt_r >= interval_cycles);

  ////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      temp_monitor_pkg::SEQ_IDLE:
        if (run_mode)
          state_nxt = temp_monitor_pkg::SEQ_LOCAL;
      temp_monitor_pkg::SEQ_LOCAL:
        if (conv_done_in)
          state_nxt = temp_monitor_pkg::SEQ_REMOTE;
      temp_monitor_pkg::SEQ_REMOTE:
        if (conv_done_in)
          state_nxt = temp_monitor_pkg::SEQ_WAIT;
      temp_monitor_pkg::SEQ_WAIT:
        if (!run_mode)
          state_nxt = temp_monitor_pkg::SEQ_IDLE;
        else if (wait_done)
          state_nxt = temp_monitor_pkg::SEQ_LOCAL;
      default:
        state_nxt = temp_monitor_pkg::SEQ_IDLE;
    endcase
  end

  wire entering_conv = (state_nxt != state_r) &&
                       ((state_nxt == temp_monitor_pkg::SEQ_LOCAL) ||
                        (state_nxt == temp_monitor_pkg::SEQ_REMOTE));
  wire local_done    = (state_r == temp_monitor_pkg::SEQ_LOCAL) && conv_done_in;
  wire remote_done   = (state_r == temp_monitor_pkg::SEQ_REMOTE) && conv_done_in;
  wire busy          = (state_r == temp_monitor_pkg::SEQ_LOCAL) ||
                       (state_r == temp_monitor_pkg::SEQ_REMOTE);

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state_r        <= temp_monitor_pkg::SEQ_IDLE;
      wait_cnt_r     <= '0;
      conv_start_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_r        <= state_nxt;
      conv_start_out <= entering_conv;
      if (state_r == temp_monitor_pkg::SEQ_WAIT && !wait_done)
        wait_cnt_r <= wait_cnt_r + 1'b1;
      else if (state_r != temp_monitor_pkg::SEQ_WAIT)
        wait_cnt_r <= CNT_W'(2);
      else
        wait_cnt_r <= wait_cnt_r;
    end
  end

  assign conv_remote_sel_out = (state_r == temp_monitor_pkg::SEQ_REMOTE);

  ////////////////////////////////////////////////////////////////////
  // Values and host-written registers

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      local_value_r  <= temp_monitor_pkg::VALUE_RESET;
      remote_value_r <= temp_monitor_pkg::VALUE_RESET;
      local_high_r   <= temp_monitor_pkg::LIMIT_HI_RESET;
      local_low_r    <= temp_monitor_pkg::LIMIT_LO_RESET;
      remote_high_r  <= temp_monitor_pkg::LIMIT_HI_RESET;
      remote_low_r   <= temp_monitor_pkg::LIMIT_LO_RESET;
      config_r       <= 8'h00;
      rate_r         <= temp_monitor_pkg::RATE_RESET;
      open_r         <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (local_done)
        local_value_r <= conv_result_in;
      if (remote_done)
      begin
        remote_value_r <= conv_result_in;
        open_r         <= sensor_open_in;
      end
      if (wr_local_high_in)
        local_high_r <= wr_data_in;
      if (wr_local_low_in)
        local_low_r <= wr_data_in;
      if (wr_remote_high_in)
        remote_high_r <= wr_data_in;
      if (wr_remote_low_in)
        remote_low_r <= wr_data_in;
      if (wr_config_in)
        config_r <= {wr_data_in[7:6], 6'h00};
      if (wr_rate_in)
        rate_r <= wr_data_in[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Comparison and flags

  logic lh_trip;
  logic ll_trip;
  logic rh_trip;
  logic rl_trip;

  limit_compare u_cmp_local
  (
    .value_in      (local_value_r),
    .high_limit_in (local_high_r),
    .low_limit_in  (local_low_r),
    .above_out     (lh_trip),
    .below_out     (ll_trip)
  );

  limit_compare u_cmp_remote
  (
    .value_in      (remote_value_r),
    .high_limit_in (remote_high_r),
    .low_limit_in  (remote_low_r),
    .above_out     (rh_trip),
    .below_out     (rl_trip)
  );

  // Flag order: local high, local low, remote high, remote low, open
  wire [4:0] trips = {lh_trip, ll_trip, rh_trip, rl_trip, open_r};

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      first_cycle_r   <= 1'b1;
      start_sampled_r <= 1'b0;
      compare_armed_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      // Sync needs two edges before the pin is trusted
      first_cycle_r   <= 1'b0;
      start_sampled_r <= !first_cycle_r || start_sampled_r;
      if (remote_done)
        compare_armed_r <= 1'b1;
      else if (!first_cycle_r && !start_sampled_r && !standby_select_pin_sync_r)
        compare_armed_r <= 1'b1;
    end
  end

  // set wins; read clears only cleared conditions
  assign flags_nxt = compare_armed_r ?
                     ((status_read_in ? 5'h00 : flags_r) | trips) :
                     flags_r;

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      flags_r       <= 5'h00;
      alarm_latch_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      flags_r <= flags_nxt;
      alarm_latch_r <= |flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read-back and alarm pin

  assign local_value_out  = local_value_r;
  assign remote_value_out = remote_value_r;
  assign local_high_out   = local_high_r;
  assign local_low_out    = local_low_r;
  assign remote_high_out  = remote_high_r;
  assign remote_low_out   = remote_low_r;
  assign config_out       = config_r;
  assign rate_out         = rate_r;
  assign status_out       = {busy, flags_r, 2'b00};
  assign alarm_n_out      = !(alarm_latch_r && !alarm_mask);

endmodule
`default_nettype wire

// ===== test/monitor_assertions.sv
// Checker for the monitor core, bound onto its ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module monitor_assertions
(
  // Inputs of the core
  input wire logic       clock_in,
  input wire logic       srst_in,
  input wire logic       clk_en_in,
  input wire logic       conv_done_in,
  input wire logic [7:0] conv_result_in,
  input wire logic       wr_local_low_in,
  input wire logic       wr_local_high_in,
  input wire logic [7:0] wr_data_in,
  input wire logic       status_read_in,
  // Outputs of the core
  input wire logic       conv_start_out,
  input wire logic       conv_remote_sel_out,
  input wire logic [7:0] local_value_out,
  input wire logic [7:0] remote_value_out,
  input wire logic [7:0] local_high_out,
  input wire logic [7:0] local_low_out,
  input wire logic [7:0] config_out,
  input wire logic [7:0] status_out,
  input wire logic       alarm_n_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  sequence local_done;
    clk_en_in && status_out[7] && conv_done_in && !conv_remote_sel_out;
  endsequence
  sequence remote_done;
    clk_en_in && status_out[7] && conv_done_in && conv_remote_sel_out;
  endsequence
  //////////////////////////////
  chk_value_reset: assert property (disable iff (1'b0)
    srst_in && clk_en_in |=> local_value_out == 8'h80 && remote_value_out == 8'h80) else $error("value not reset");
  chk_remote_store: assert property (
    remote_done |=> remote_value_out == $past(conv_result_in)) else $error("remote value not stored");
  chk_remote_follows: assert property (
    local_done |-> ##[1:3] (conv_start_out && conv_remote_sel_out)) else $error("no remote start");
  chk_low_write: assert property (
    clk_en_in && wr_local_low_in |=> local_low_out == $past(wr_data_in)) else $error("limit not written");
  chk_mask_hides: assert property (
    config_out[7] |-> alarm_n_out) else $error("masked alarm shown");
  chk_alarm_raise: assert property (
    (clk_en_in && !config_out[7] && |status_out[6:2])[*3] |-> !alarm_n_out) else $error("alarm not raised");
  chk_flag_held: assert property (
    clk_en_in && status_read_in && !wr_local_high_in && !conv_done_in && status_out[6]
    && $signed(local_value_out) > $signed(local_high_out) |=> status_out[6]) else $error("live flag cleared");
  chk_standby_idle: assert property (
    (config_out[6] && !status_out[7])[*2] |=> !conv_start_out) else $error("start in standby");
endmodule
bind dual_temp_monitor_core monitor_assertions chk
(
  .clock_in(clock_in), .srst_in(srst_in), .clk_en_in(clk_en_in), .conv_done_in(conv_done_in),
  .conv_result_in(conv_result_in), .wr_local_low_in(wr_local_low_in), .wr_local_high_in(wr_local_high_in),
  .wr_data_in(wr_data_in), .status_read_in(status_read_in), .conv_start_out(conv_start_out),
  .conv_remote_sel_out(conv_remote_sel_out), .local_value_out(local_value_out),
  .remote_value_out(remote_value_out), .local_high_out(local_high_out), .local_low_out(local_low_out),
  .config_out(config_out), .status_out(status_out), .alarm_n_out(alarm_n_out)
);
`default_nettype wire

// ===== test/conv_model.sv
// Converter stand-in: answers each start with done and a result.
// Assumes start is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
`default_nettype none
module conv_model
(
  // Core side
  input  wire logic       clock_in,
  input  wire logic       start_in,
  input  wire logic       remote_sel_in,
  // Bench settings
  input  wire logic [7:0] local_temp_in,
  input  wire logic [7:0] remote_temp_in,
  input  wire logic [7:0] delay_in,
  // Answer
  output logic            done_out,
  output logic [7:0]      result_out
);
  initial
  begin
    done_out = 1'b0;
    result_out = 8'hA5;
  end
  // Result held one cycle only; junk otherwise
  always @(posedge clock_in)
    if (start_in === 1'b1)
    begin
      repeat (delay_in) @(posedge clock_in);
      done_out <= 1'b1;
      result_out <= remote_sel_in ? remote_temp_in : local_temp_in;
      @(posedge clock_in);
      done_out <= 1'b0;
      result_out <= ~result_out;
    end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Bench: converter model, reference model of flags, checks.
// Assumes package, core, checker and conv_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        pin = 1'b0;
  logic        rd_stat = 1'b0;
  logic [5:0]  wr_sel = 6'h00;
  logic [7:0]  wr_data = 8'h00;
  logic [7:0]  lt = 8'h00;
  logic [7:0]  rt = 8'h00;
  logic [7:0]  dly = 8'h01;
  logic [7:0]  d;
  logic [4:0]  flg = 5'h00;
  logic [31:0] seed = 32'hBB2D;
  int          mismatches = 0;
  int          tests_run = 0;
  int          starts = 0;
  int          mask = 0;
  int          lv;
  int          rv;
  int          lim [4];
  wire         start, sel, done, alarm_n;
  wire [7:0]   res, lvo, rvo, sto, lho, llo, rho, rlo, cfgo;
  wire [2:0]   rate;
  wire [47:0]  rbv = {5'h00, rate, cfgo, rlo, rho, llo, lho};

  always #5 clock_in = ~clock_in;
  always @(posedge clock_in)
    if (start === 1'b1)
      starts++;

  dual_temp_monitor_core #(.BASE_PERIOD_MS(1)) uut
  (
    .clock_in(clock_in), .srst_in(srst_in), .clk_en_in(1'b1), .standby_select_pin_in(pin),
    .conv_start_out(start), .conv_remote_sel_out(sel), .conv_done_in(done), .conv_result_in(res),
    .sensor_open_in(1'b0), .wr_local_high_in(wr_sel[0]), .wr_local_low_in(wr_sel[1]),
    .wr_remote_high_in(wr_sel[2]), .wr_remote_low_in(wr_sel[3]), .wr_config_in(wr_sel[4]),
    .wr_rate_in(wr_sel[5]), .wr_data_in(wr_data), .status_read_in(rd_stat), .local_value_out(lvo),
    .remote_value_out(rvo), .local_high_out(lho), .local_low_out(llo), .remote_high_out(rho),
    .remote_low_out(rlo), .config_out(cfgo), .rate_out(rate), .status_out(sto), .alarm_n_out(alarm_n)
  );
  conv_model conv
  (
    .clock_in(clock_in), .start_in(start), .remote_sel_in(sel), .local_temp_in(lt),
    .remote_temp_in(rt), .delay_in(dly), .done_out(done), .result_out(res)
  );
  //////////////////////////////
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [4:0] trips();
    return {lv > lim[0], lv < lim[1], rv > lim[2], rv < lim[3], 1'b0};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset(input logic p);
    @(posedge clock_in);
    srst_in <= 1'b1;
    pin <= p;
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    lv = -128;
    rv = -128;
    lim = '{127, -55, 127, -55};
    mask = 0;
    #1;
  endtask
  task automatic wr(input int i, input logic [7:0] v);
    @(posedge clock_in);
    wr_sel <= 6'h01 << i;
    wr_data <= v;
    @(posedge clock_in);
    wr_sel <= 6'h00;
    if (i < 4)
      lim[i] = int'($signed(v));
    if (i == 4)
      mask = int'(v[7]);
    #1;
  endtask
  task automatic rd();
    @(posedge clock_in);
    rd_stat <= 1'b1;
    @(posedge clock_in);
    rd_stat <= 1'b0;
    flg = trips();
  endtask
  task automatic expect_flags();
    repeat (3) @(posedge clock_in);
    #1;
    check({3'h0, sto[6:2]}, {3'h0, flg});
    check({7'h00, alarm_n}, {7'h00, ~|flg || mask != 0});
  endtask
  task automatic wait_done(input logic rem);
    int k;
    k = 0;
    do
    begin
      @(posedge clock_in);
      k++;
    end
    while (!(done && sel === rem) && k < 500);
    #1;
    check({7'h00, k < 500}, 8'h01);
    check({7'h00, sto[7]}, {7'h00, !rem});
    if (rem)
      rv = int'($signed(rt));
    else
      lv = int'($signed(lt));
    if (rem)
      flg = flg | trips();
  endtask
  //////////////////////////////
  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    do_reset(1'b0);
    check(lvo, 8'(lv));
    check(rvo, 8'(rv));
    flg = trips();
    expect_flags();
    wr(4, 8'h80);
    expect_flags();
    for (int i = 0; i < 6; i++)
    begin
      d = rnd();
      wr(i, d);
      check(rbv[i*8 +: 8], i == 4 ? d & 8'hC0 : i == 5 ? d & 8'h07 : d);
    end
    wr(0, 8'h20);
    wr(1, 8'h80);
    wr(2, 8'h7F);
    wr(3, 8'h80);
    wr(4, 8'h00);
    rd();
    expect_flags();
    check(8'(starts), 8'h00);
    lt = 8'h40 | (rnd() & 8'h1F);
    rt = rnd() & 8'h3F;
    @(posedge clock_in);
    pin <= 1'b1;
    wait_done(1'b0);
    check(lvo, lt);
    wait_done(1'b1);
    check(rvo, rt);
    expect_flags();
    rd();
    expect_flags();
    wr(4, 8'h40);
    wr(0, 8'h7F);
    rd();
    expect_flags();
    dly = 8'h14;
    do_reset(1'b1);
    flg = 5'h00;
    wait_done(1'b0);
    expect_flags();
    wait_done(1'b1);
    check(rvo, rt);
    expect_flags();
    give_verdict();
  end
endmodule
`default_nettype wire
